// >>> sar_defs.svh
/*
 Constants for the successive-approximation sequencer.
 Assumes inclusion by bare name from each design file.
*/
`ifndef SAR_DEFS_SVH
`define SAR_DEFS_SVH
`define SAR_RESOLUTION 8
`define SAR_FIRST_CODE 8'h80
`define SAR_FIRST_STEP 8'h40
`define SAR_RESULT_CLEAR 8'h00
`define SAR_SETTLE_US 10
`define SAR_CLK_MHZ 25
`define SAR_SETTLE_CYCLES ((`SAR_SETTLE_US) * (`SAR_CLK_MHZ))
`define SAR_CNT_W 9
`endif

// >>> sar_pkg.sv
/*
 Types shared by the sequencer modules.
 Assumes sar_defs.svh is compiled alongside.
*/
package sar_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_LOAD = 3'b001,
      ST_WAIT_DAC = 3'b011,
      ST_SETTLE = 3'b010,
      ST_SAMPLE = 3'b110,
      ST_SHUT = 3'b111
   } sar_state_t;
endpackage

// >>> settle_if.sv
/*
 Handshake between the sequencer and its settle timer.
 Assumes one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface settle_if;
   logic start;
   logic expired;
   modport seq (output start, input expired);
   modport timer (input start, output expired);
endinterface
`default_nettype wire

// >>> settle_timer.sv
/*
 Fixed post-stability delay timer, counted in core clock cycles.
 Assumes start pulses only while the sequencer waits for it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sar_defs.svh"
module settle_timer #(
   parameter int CYCLES = `SAR_SETTLE_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Sequencer side
   settle_if.timer tif
);
   logic [`SAR_CNT_W-1:0] cnt_reg, cnt_next;
   logic exp_reg, exp_next;
   localparam logic [`SAR_CNT_W-1:0] LOAD = `SAR_CNT_W'(CYCLES - 1);

   ////////////////////////////////////////////////////////////////
   // Count down; expired is a one-cycle pulse at the end
   always_comb begin
      cnt_next = cnt_reg;
      exp_next = 1'b0;
      if (tif.start) begin
         cnt_next = LOAD;
      end else if (cnt_reg != '0) begin
         cnt_next = cnt_reg - 1'b1;
         exp_next = (cnt_reg == `SAR_CNT_W'(1));
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt_reg <= '0;
         exp_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         exp_reg <= exp_next;
      end
   end
   assign tif.expired = exp_reg;
endmodule // settle_timer
`default_nettype wire

// >>> sar_sequencer.sv
/*
 Successive-approximation conversion sequencer driving a reference DAC and
 an analog comparator. Assumes the DAC, comparator, trigger and terminate
 come from outside the clock domain; the hold circuit keeps the input stable.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sar_defs.svh"

// Function
// - Build an 8-bit result by successive approximation with comparator and DAC.
// - Runs entirely from the slow core clock, no high-speed clock needed.
// - Each conversion clears the result and loads trial code 0x80.
// - Step starts at 64, halves per trial; bit counter counts down resolution.
// - Write code, wait DAC stable, wait 10 us more, then sample comparator.
// - Input above DAC: next code adds step, else subtracts step.
// - After counter decrement, OR decision into result at counter position.
// - At end or terminate: stop DAC, ground reference, disable DAC and comparator.
module sar_sequencer
   import sar_pkg::*;
#(
   parameter int RESOLUTION = `SAR_RESOLUTION,
   parameter int SETTLE_CYCLES = `SAR_SETTLE_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Scheduling
   input wire logic periodic_trigger,
   input wire logic terminate,
   // Comparator
   input wire logic analog_comparator_a,
   output logic comparator_enable,
   output logic comparator_ground_reference,
   // Reference DAC
   input wire logic dac_stable,
   output logic dac_enable,
   output logic dac_output_enable,
   output logic dac_load,
   output logic [RESOLUTION-1:0] trial_code,
   // Result
   output logic [RESOLUTION-1:0] result,
   output logic done
);
   import sar_pkg::*;

   settle_if tif();
   settle_timer #(.CYCLES(SETTLE_CYCLES)) u_timer (
      .core_clk(core_clk),
      .rst(rst),
      .tif(tif)
   );

   ////////////////////////////////////////////////////////////////
   // Two-flop synchronisers for asynchronous inputs
   // Comparator and stable arrive two cycles late; the wait state allows for that
   logic [1:0] trig_sync_reg, term_sync_reg, cmp_sync_reg, stab_sync_reg;
   logic trig_prev_reg;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         trig_sync_reg <= 2'h0;
         term_sync_reg <= 2'h0;
         cmp_sync_reg <= 2'h0;
         stab_sync_reg <= 2'h0;
         trig_prev_reg <= 1'b0;
      end else begin
         trig_sync_reg <= {trig_sync_reg[0], periodic_trigger};
         term_sync_reg <= {term_sync_reg[0], terminate};
         cmp_sync_reg <= {cmp_sync_reg[0], analog_comparator_a};
         stab_sync_reg <= {stab_sync_reg[0], dac_stable};
         trig_prev_reg <= trig_sync_reg[1];
      end
   end
   // Edge detect starts at the trigger's idle low level, so reset makes no false edge
   wire trig_rise = trig_sync_reg[1] & ~trig_prev_reg;
   wire term_s = term_sync_reg[1];
   wire input_above_flag = cmp_sync_reg[1];
   wire stable_s = stab_sync_reg[1];

   ////////////////////////////////////////////////////////////////
   // Sequencer state
   sar_state_t state_reg, state_next;
   logic [RESOLUTION-1:0] code_reg, code_next, step_reg, step_next;
   logic [RESOLUTION-1:0] res_reg, res_next;
   logic [3:0] bit_index_reg, bit_index_next;
   logic cmp_en_reg, cmp_en_next, gnd_ref_reg, gnd_ref_next;
   logic dac_en_reg, dac_en_next, dac_out_reg, dac_out_next;
   logic load_reg, load_next, done_reg, done_next, start_next, start_reg;
   logic [3:0] idx_dec;
   // History of dac_load; the synchronised stable flag lags the pin by two cycles
   logic [1:0] load_dly_reg, load_dly_next;

   // Next state; terminate overrides every step and powers the analog down
   always_comb begin
      state_next = state_reg;
      code_next = code_reg;
      step_next = step_reg;
      res_next = res_reg;
      bit_index_next = bit_index_reg;
      cmp_en_next = cmp_en_reg;
      gnd_ref_next = gnd_ref_reg;
      dac_en_next = dac_en_reg;
      dac_out_next = dac_out_reg;
      load_next = 1'b0;
      done_next = 1'b0;
      start_next = 1'b0;
      load_dly_next = {load_dly_reg[0], load_reg};
      idx_dec = bit_index_reg - 4'h1;
      case (state_reg)
         ST_IDLE: begin
            if (trig_rise && !term_s) begin
               state_next = ST_LOAD;
               cmp_en_next = 1'b1;
               gnd_ref_next = 1'b0;
               dac_en_next = 1'b1;
               dac_out_next = 1'b1;
               res_next = `SAR_RESULT_CLEAR;
               code_next = `SAR_FIRST_CODE;
               step_next = `SAR_FIRST_STEP;
               bit_index_next = 4'(RESOLUTION);
            end
         end
         ST_LOAD: begin
            load_next = 1'b1;
            state_next = ST_WAIT_DAC;
         end
         ST_WAIT_DAC: begin
            // Until the DAC's answer to this load has crossed both sync flops,
            // stable_s may still be the flag of the previous code
            if (stable_s && !load_reg && (load_dly_reg == 2'h0)) begin
               start_next = 1'b1;
               state_next = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            // An expiry left over from an aborted count can coincide with the new start
            if (tif.expired && !start_reg) begin
               state_next = ST_SAMPLE;
            end
         end
         ST_SAMPLE: begin
            // Decision, step halving and bit fill in one cycle
            code_next = input_above_flag ? code_reg + step_reg
                                         : code_reg - step_reg;
            step_next = step_reg >> 1;
            bit_index_next = idx_dec;
            if (input_above_flag) begin
               res_next = res_reg | (RESOLUTION'(1) << idx_dec);
            end
            state_next = (idx_dec == 4'h0) ? ST_SHUT : ST_LOAD;
         end
         ST_SHUT: begin
            dac_out_next = 1'b0;
            gnd_ref_next = 1'b1;
            dac_en_next = 1'b0;
            cmp_en_next = 1'b0;
            done_next = 1'b1;
            state_next = ST_IDLE;
         end
         default: state_next = ST_IDLE;
      endcase
      if (term_s && state_reg != ST_IDLE) begin
         state_next = ST_IDLE;
         dac_out_next = 1'b0;
         gnd_ref_next = 1'b1;
         dac_en_next = 1'b0;
         cmp_en_next = 1'b0;
         done_next = 1'b0;
         load_next = 1'b0;
         start_next = 1'b0;
      end
   end

   // Registers; clocked by the slow core clock only
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         code_reg <= `SAR_FIRST_CODE;
         step_reg <= `SAR_FIRST_STEP;
         res_reg <= `SAR_RESULT_CLEAR;
         bit_index_reg <= 4'h0;
         cmp_en_reg <= 1'b0;
         gnd_ref_reg <= 1'b1;
         dac_en_reg <= 1'b0;
         dac_out_reg <= 1'b0;
         load_reg <= 1'b0;
         done_reg <= 1'b0;
         start_reg <= 1'b0;
         load_dly_reg <= 2'h0;
      end else begin
         state_reg <= state_next;
         code_reg <= code_next;
         step_reg <= step_next;
         res_reg <= res_next;
         bit_index_reg <= bit_index_next;
         cmp_en_reg <= cmp_en_next;
         gnd_ref_reg <= gnd_ref_next;
         dac_en_reg <= dac_en_next;
         dac_out_reg <= dac_out_next;
         load_reg <= load_next;
         done_reg <= done_next;
         start_reg <= start_next;
         load_dly_reg <= load_dly_next;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Outputs straight from flip-flops
   assign tif.start = start_reg;
   assign comparator_enable = cmp_en_reg;
   assign comparator_ground_reference = gnd_ref_reg;
   assign dac_enable = dac_en_reg;
   assign dac_output_enable = dac_out_reg;
   assign dac_load = load_reg;
   assign trial_code = code_reg;
   assign result = res_reg;
   assign done = done_reg;
endmodule // sar_sequencer
`default_nettype wire

// >>> sar_sequencer_monitor.sv
/* Port checker for sar_sequencer.
 Assumes a bind from the bench, one clock. */
`timescale 1ns/1ps
`default_nettype none
module sar_sequencer_monitor #(
   parameter int RESOLUTION = 8,
   parameter int SETTLE_CYCLES = 250
) (
   // Clock, reset, inputs
   input wire logic core_clk,
   input wire logic rst,
   input wire logic terminate,
   input wire logic analog_comparator_a,
   input wire logic dac_stable,
   // Outputs
   input wire logic comparator_enable,
   input wire logic comparator_ground_reference,
   input wire logic dac_enable,
   input wire logic dac_output_enable,
   input wire logic dac_load,
   input wire logic [RESOLUTION-1:0] trial_code,
   input wire logic [RESOLUTION-1:0] result,
   input wire logic done
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   int stab_reg;
   int stab_next;
   ////////////////////////////////////////////////////////////
   // Unbroken stable cycles since the last load
   always_comb begin
      stab_next = (dac_load || !dac_stable) ? 0 : stab_reg + 1;
   end
   always_ff @(posedge core_clk) begin
      stab_reg <= rst ? 0 : stab_next;
   end
   AST_DONE_PULSE: assert property (done |=> !done)
      else $error("done wider than a cycle");
   AST_DONE_OFF: assert property (done |-> !dac_enable && !comparator_enable
      && comparator_ground_reference && !dac_output_enable) else $error("on at done");
   AST_TERM_OFF: assert property ($rose(terminate) |-> ##[1:4] !dac_enable
      && !comparator_enable && comparator_ground_reference) else $error("abort kept power");
   AST_IDLE_GND: assert property (!comparator_enable |-> comparator_ground_reference
      && !dac_output_enable) else $error("reference not grounded");
   AST_START: assert property ($rose(dac_enable) |-> trial_code == 8'h80
      && result == 8'h00) else $error("bad start values");
   AST_LOAD_ON: assert property (dac_load |-> dac_enable && comparator_enable)
      else $error("load while off");
   AST_SETTLED: assert property ($changed(trial_code) && $past(dac_enable)
      && dac_enable && !$past(rst) |-> stab_reg >= SETTLE_CYCLES) else $error("early sample");
   AST_DIR: assert property ($changed(trial_code) && $past(dac_enable) && dac_enable
      && !$past(rst) |-> (trial_code > $past(trial_code)) == $past(analog_comparator_a))
      else $error("wrong step direction");
   AST_FILL: assert property ($changed(result) && !$past(rst) && !$rose(dac_enable)
      |-> $onehot(result ^ $past(result)) && (result & $past(result)) == $past(result))
      else $error("bad result update");
endmodule // sar_sequencer_monitor
`default_nettype wire

// >>> dac_comp_model.sv
/* Reference DAC and comparator on a held level.
 Assumes one clock; the bench holds the level. */
`timescale 1ns/1ps
`default_nettype none
module dac_comp_model #(
   parameter int DELAY = 2
) (
   // Sequencer side
   input wire logic core_clk,
   input wire logic dac_enable,
   input wire logic dac_output_enable,
   input wire logic dac_load,
   input wire logic [7:0] code,
   input wire logic comparator_enable,
   input wire logic comparator_ground_reference,
   // Held level and answers
   input wire logic [7:0] vin,
   output logic dac_stable,
   output logic comp_out
);
   logic [7:0] level = 8'h00;
   int cnt = 0;
   logic toggle = 1'b0;
   // Stable drops the cycle after every load, so the load cycle still shows the old flag
   always @(posedge core_clk) begin
      toggle <= ~toggle;
      if (dac_load) begin
         level <= code;
         cnt <= 0;
      end else if (cnt < DELAY) cnt <= cnt + 1;
   end
   assign dac_stable = dac_enable && cnt >= DELAY;
   // Unpowered comparator answers with noise
   assign comp_out = (comparator_enable && dac_output_enable && !comparator_ground_reference)
      ? (vin > level) : toggle;
endmodule // dac_comp_model
`default_nettype wire

// >>> sar_sequencer_tb_top.sv
/* Bench for sar_sequencer with the DAC model.
 Assumes design files compiled first. */
`timescale 1ns/1ps
`default_nettype none
module sar_sequencer_tb_top;
   localparam int RESOLUTION = 8;
   localparam int SETTLE_CYCLES = 3;
   logic core_clk = 1'b0, rst = 1'b1, trig = 1'b0, term = 1'b0;
   logic [7:0] vin = 8'h00, code, res;
   logic cmp_a, stab, c_en, c_gnd, d_en, d_oe, load, done;
   logic [3:0] pwr;
   int miscompares = 0, checked = 0, cycles = 0, dones = 0, loads = 0;
   logic [7:0] vals [6] = '{8'h00, 8'hff, 8'h80, 8'h7f, 8'h55, 8'h01};
   assign pwr = {d_en, d_oe, c_en, c_gnd};
   always #20 core_clk = ~core_clk;
   // Done count and hang guard
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (done === 1'b1) dones <= dones + 1;
      // Trials of the running conversion; cleared while the DAC is off
      if (d_en === 1'b0) begin
         loads <= 0;
      end else if (load === 1'b1) begin
         loads <= loads + 1;
      end
      if (cycles == 20000) begin
         miscompares++;
         end_sim();
      end
   end
   sar_sequencer #(.RESOLUTION(RESOLUTION), .SETTLE_CYCLES(SETTLE_CYCLES)) dut (
      .core_clk(core_clk), .rst(rst), .periodic_trigger(trig), .terminate(term),
      .analog_comparator_a(cmp_a), .comparator_enable(c_en), .comparator_ground_reference(c_gnd),
      .dac_stable(stab), .dac_enable(d_en), .dac_output_enable(d_oe), .dac_load(load),
      .trial_code(code), .result(res), .done(done));
   dac_comp_model #(.DELAY(2)) partner (.core_clk(core_clk), .dac_enable(d_en),
      .dac_output_enable(d_oe), .dac_load(load), .code(code), .comparator_enable(c_en),
      .comparator_ground_reference(c_gnd), .vin(vin), .dac_stable(stab), .comp_out(cmp_a));
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // Held level stays put for the whole conversion
   task automatic pulse(input logic [7:0] v);
      @(posedge core_clk);
      vin <= v;
      trig <= 1'b1;
      repeat (2) @(posedge core_clk);
      trig <= 1'b0;
   endtask
   task automatic t_conv(input logic [7:0] v);
      logic [7:0] c, r, s;
      int n;
      c = 8'h80;
      s = 8'h40;
      for (int b = 7; b >= 0; b--) begin
         r[b] = v > c;
         c = r[b] ? c + s : c - s;
         s = s >> 1;
      end
      pulse(v);
      for (n = 0; done !== 1'b1 && n < 400; n++) tick(1);
      cmp({7'h0, done}, 8'h01);
      cmp({7'h0, n >= 8 * SETTLE_CYCLES}, 8'h01);
      cmp(res, r);
      cmp(code, c);
      cmp(8'(loads), 8'(RESOLUTION));
      cmp({4'h0, pwr}, 8'h01);
      tick(1);
      cmp({7'h0, done}, 8'h00);
      $display("conversion %h ended", v);
   endtask
   task automatic t_busy();
      int d0;
      d0 = dones;
      pulse(8'h3c);
      tick(10);
      cmp({4'h0, pwr}, 8'h0e);
      t_conv(8'h3c);
      tick(300);
      cmp(8'(dones - d0), 8'h01);
      $display("busy trigger ended");
   endtask
   task automatic t_abort();
      int d0;
      d0 = dones;
      pulse(8'h66);
      tick(20);
      @(posedge core_clk);
      term <= 1'b1;
      tick(5);
      cmp({4'h0, pwr}, 8'h01);
      pulse(8'h66);
      tick(5);
      cmp({4'h0, pwr}, 8'h01);
      @(posedge core_clk);
      term <= 1'b0;
      tick(300);
      cmp(8'(dones - d0), 8'h00);
      $display("abort ended");
   endtask
   task automatic t_reset();
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      tick(4);
      cmp({4'h0, pwr}, 8'h01);
      cmp(code, 8'h80);
      cmp(res, 8'h00);
      $display("reset ended");
   endtask
   initial begin
      t_reset();
      foreach (vals[i]) t_conv(vals[i]);
      t_busy();
      t_abort();
      t_conv(8'h99);
      end_sim();
   end
endmodule // sar_sequencer_tb_top
bind sar_sequencer sar_sequencer_monitor #(.RESOLUTION(RESOLUTION),
   .SETTLE_CYCLES(SETTLE_CYCLES)) mon (.core_clk(core_clk), .rst(rst), .terminate(terminate),
   .analog_comparator_a(analog_comparator_a), .dac_stable(dac_stable),
   .comparator_enable(comparator_enable), .dac_enable(dac_enable),
   .comparator_ground_reference(comparator_ground_reference), .dac_load(dac_load),
   .dac_output_enable(dac_output_enable), .trial_code(trial_code), .result(result), .done(done));
`default_nettype wire
